/* File: rtl/mco_pkg.sv */
/*
 * Constants shared by the main clock switchover control: APB register map,
 * field positions, reset values, sequencer states and timing figures.
 * Assumes a single 20 MHz register clock and APB with 32-bit data.
 */
`default_nettype none

package mco_pkg;

    // ------------------------------------------------------------------
    // bus and timing
    // ------------------------------------------------------------------
    localparam int          REF_CLK_HZ      = 20000000;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    // cycles of the old and the new clock that must pass before handover
    localparam logic [1:0]  SW_MIN_CYCLES   = 2'h2;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SYS_CLK_CTRL_OFS = 12'h000;
    localparam logic [ADDR_W-1:0] OSC_CTRL_OFS     = 12'h004;
    localparam logic [ADDR_W-1:0] SW_STATUS_OFS    = 12'h008;

    // ------------------------------------------------------------------
    // system_clock_control fields
    // ------------------------------------------------------------------
    localparam int CPU_CLOCK_STATUS_BIT  = 7;
    localparam int PLL_SELECT_BIT        = 6;
    localparam int MAIN_CLOCK_STATUS_BIT = 5;
    localparam int MAIN_CLOCK_SELECT_BIT = 4;

    // ------------------------------------------------------------------
    // osc_ctrl fields
    // ------------------------------------------------------------------
    localparam int INTERNAL_OSC_STOP_BIT = 0;
    localparam int MAIN_OSC_STOP_BIT     = 1;
    localparam int OSC_MODE_SELECT_BIT   = 2;
    localparam int EXT_CLOCK_SEL_BIT     = 3;
    localparam int PLL_RUN_CONTROL_BIT   = 4;

    // ------------------------------------------------------------------
    // sw_status fields
    // ------------------------------------------------------------------
    localparam int SW_PENDING_BIT        = 0;
    localparam int STOP_REFUSED_BIT      = 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic       RST_MAIN_CLOCK_SELECT = 1'b0;
    localparam logic       RST_INTERNAL_OSC_STOP = 1'b0;
    localparam logic       RST_MAIN_OSC_STOP     = 1'b1;
    localparam logic       RST_OSC_MODE_SELECT   = 1'b0;
    localparam logic       RST_EXT_CLOCK_SEL     = 1'b0;
    localparam logic       RST_PLL_RUN_CONTROL   = 1'b0;
    localparam logic       RST_PLL_SELECT        = 1'b0;

    // ------------------------------------------------------------------
    // clock source codes on cpu_src_o / periph_src_o
    // ------------------------------------------------------------------
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_HIGH_SPD = 2'h1;
    localparam logic [1:0] SRC_PLL      = 2'h2;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_WAIT = 2'b10
    } mco_seq_state_t;

endpackage : mco_pkg

`default_nettype wire

/* File: rtl/mco_apb_slv.sv */
/*
 * APB slave handshake for the clock switchover control: one wait state,
 * a write strobe and a read-capture strobe.
 * Assumes an APB master that holds the request until pready is seen.
 */
`default_nettype none

module mco_apb_slv
    import mco_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic psel_i,
    input  wire logic penable_i,
    input  wire logic pwrite_i,
    output logic      pready_o,
    output logic      wr_stb_o,
    output logic      rd_cap_o
);

    logic pready_q;
    logic pready_d;

    // ------------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------------
    // pready rises in the second access cycle and drops after completion
    assign pready_d = psel_i & penable_i & ~pready_q;
    assign wr_stb_o = psel_i & penable_i & pready_q & pwrite_i;
    // read data is captured at setup so it is stable through access
    assign rd_cap_o = psel_i & ~penable_i & ~pwrite_i;
    assign pready_o = pready_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
        end
    end

endmodule : mco_apb_slv

`default_nettype wire

/* File: rtl/mco_sw_seq.sv */
/*
 * Switchover sequencer: waits for cycles of both the old and the new main
 * clock, then hands over on an edge of the old clock.
 * Assumes oscillator ticks are one-cycle pulses synchronous to ref_clk_i.
 */
`default_nettype none

module mco_sw_seq
    import mco_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic request_i,
    input  wire logic old_tick_i,
    input  wire logic new_tick_i,
    output logic      pending_o,
    output logic      done_o
);

    mco_seq_state_t state_q;
    mco_seq_state_t state_d;
    logic [1:0]     old_cnt_q;
    logic [1:0]     new_cnt_q;
    logic [1:0]     old_cnt_d;
    logic [1:0]     new_cnt_d;
    logic           counts_met;

    function automatic logic [1:0] sat_inc(input logic [1:0] v,
                                           input logic       tick);
        sat_inc = (tick && v < SW_MIN_CYCLES) ? v + 2'h1 : v;
    endfunction : sat_inc

    // ------------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------------
    // two new-clock periods in old cycles gives 2*fold/fnew, rounded up
    assign old_cnt_d  = sat_inc(old_cnt_q, old_tick_i);
    assign new_cnt_d  = sat_inc(new_cnt_q, new_tick_i);
    // the old tick that completes the count is the handover edge itself,
    // otherwise a third old cycle would pass before the switch
    assign counts_met = (old_cnt_d == SW_MIN_CYCLES) &&
                        (new_cnt_d == SW_MIN_CYCLES);
    // handover only on an old-clock edge, so no runt pulse
    assign done_o     = (state_q == SEQ_WAIT) & request_i &
                        counts_met & old_tick_i;
    assign pending_o  = (state_q == SEQ_WAIT);

    always_comb begin
        state_d = state_q;
        case (state_q)
            SEQ_IDLE: begin
                if (request_i) begin
                    state_d = SEQ_WAIT;
                end
            end
            SEQ_WAIT: begin
                if (!request_i || done_o) begin
                    state_d = SEQ_IDLE;
                end
            end
            default: begin
                state_d = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q   <= SEQ_IDLE;
            old_cnt_q <= 2'h0;
            new_cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_q != SEQ_WAIT) begin
                old_cnt_q <= 2'h0;
                new_cnt_q <= 2'h0;
            end else begin
                old_cnt_q <= old_cnt_d;
                new_cnt_q <= new_cnt_d;
            end
        end
    end

endmodule : mco_sw_seq

`default_nettype wire

/* File: rtl/mco_top.sv */
/*
 * Main clock switchover control: APB registers for clock selection and
 * oscillator control, delayed glitch-free main clock handover, PLL
 * selection and the source codes for the CPU and peripheral clocks.
 * Assumes oscillator ticks arrive as pulses synchronous to ref_clk_i and
 * that the clock multiplexers downstream follow cpu_src_o/periph_src_o.
 */
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none

// Overview of operation
// - bit 4 selects internal or high-speed main
// - old clock runs on for bounded cycles
// - bit 7 shows cpu on main or not
// - bit 5 shows main clock current source
// - peripheral clock follows every cpu source change
// - to high-speed: two cycles or scaled ratio
// - to internal: scaled ratio or two cycles
// - counts are in pre-switch cpu cycles
// - fractional counts round up to whole cycles
module mco_top
    import mco_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    input  wire logic              fih_tick_i,
    input  wire logic              fmx_tick_i,
    input  wire logic              fpll_tick_i,
    output logic      [1:0]        cpu_src_o,
    output logic      [1:0]        periph_src_o,
    output logic                   internal_osc_en_o,
    output logic                   x1_osc_en_o,
    output logic                   ext_clk_en_o,
    output logic                   pll_en_o
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic              main_clock_select_q;
    logic              main_clock_status_q;
    logic              cpu_clock_status_q;
    logic              pll_select_q;
    logic              internal_osc_stop_q;
    logic              main_osc_stop_q;
    logic              osc_mode_select_q;
    logic              ext_clock_input_select_q;
    logic              pll_run_control_q;
    logic              stop_refused_q;
    logic [DATA_W-1:0] prdata_q;
    logic              pslverr_q;
    logic [1:0]        cpu_src_q;
    logic [1:0]        periph_src_q;
    logic              internal_osc_en_q;
    logic              x1_osc_en_q;
    logic              ext_clk_en_q;
    logic              pll_en_q;

    logic              wr_stb;
    logic              rd_cap;
    logic              sel_sys;
    logic              sel_osc;
    logic              sel_sts;
    logic              addr_ok;
    logic              wr_sys;
    logic              wr_osc;
    logic              wr_sts;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] sys_rd;
    logic [DATA_W-1:0] osc_rd;
    logic [DATA_W-1:0] sts_rd;

    logic              sw_request;
    logic              sw_pending;
    logic              sw_done;
    logic              old_tick;
    logic              new_tick;
    logic              pll_done;
    logic              pll_request;

    logic              want_int_stop;
    logic              want_main_stop;
    logic              int_stop_ok;
    logic              main_stop_ok;
    logic              refuse_evt;
    logic              pll_stop_ok;
    logic              ext_sel_ok;
    logic [1:0]        src_d;

    function automatic logic [DATA_W-1:0] bit_at(input int pos,
                                                 input logic v);
        bit_at = {{(DATA_W-1){1'b0}}, v} << pos;
    endfunction : bit_at

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    mco_apb_slv u_apb (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .pready_o  (pready_o),
        .wr_stb_o  (wr_stb),
        .rd_cap_o  (rd_cap)
    );

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    assign sel_sys = (paddr_i == SYS_CLK_CTRL_OFS);
    assign sel_osc = (paddr_i == OSC_CTRL_OFS);
    assign sel_sts = (paddr_i == SW_STATUS_OFS);
    assign addr_ok = sel_sys | sel_osc | sel_sts;
    assign wr_sys  = wr_stb & sel_sys;
    assign wr_osc  = wr_stb & sel_osc;
    assign wr_sts  = wr_stb & sel_sts;

    assign sys_rd = bit_at(CPU_CLOCK_STATUS_BIT, cpu_clock_status_q)
                  | bit_at(PLL_SELECT_BIT, pll_select_q)
                  | bit_at(MAIN_CLOCK_STATUS_BIT, main_clock_status_q)
                  | bit_at(MAIN_CLOCK_SELECT_BIT, main_clock_select_q);
    assign osc_rd = bit_at(INTERNAL_OSC_STOP_BIT, internal_osc_stop_q)
                  | bit_at(MAIN_OSC_STOP_BIT, main_osc_stop_q)
                  | bit_at(OSC_MODE_SELECT_BIT, osc_mode_select_q)
                  | bit_at(EXT_CLOCK_SEL_BIT, ext_clock_input_select_q)
                  | bit_at(PLL_RUN_CONTROL_BIT, pll_run_control_q);
    assign sts_rd = bit_at(SW_PENDING_BIT, sw_pending | pll_request)
                  | bit_at(STOP_REFUSED_BIT, stop_refused_q);
    assign rd_mux = sel_sys ? sys_rd :
                    sel_osc ? osc_rd :
                    sel_sts ? sts_rd : {DATA_W{1'b0}};

    // ------------------------------------------------------------------
    // write guards
    // ------------------------------------------------------------------
    // stopping the oscillator that feeds the cpu would hang the part, so
    // such a stop is dropped and flagged instead of obeyed
    assign want_int_stop  = pwdata_i[INTERNAL_OSC_STOP_BIT];
    assign want_main_stop = pwdata_i[MAIN_OSC_STOP_BIT];
    assign int_stop_ok    = main_clock_status_q & ~sw_pending;
    assign main_stop_ok   = ~main_clock_status_q & ~sw_pending;
    // pll may only stop once the cpu has left it
    assign pll_stop_ok    = ~cpu_clock_status_q & ~pll_select_q;
    // crystal and external input cannot swap under a running main clock
    assign ext_sel_ok     = ~main_clock_status_q;
    assign refuse_evt     = wr_osc &
                            ((want_int_stop & ~internal_osc_stop_q &
                              ~int_stop_ok) |
                             (want_main_stop & ~main_osc_stop_q &
                              ~main_stop_ok));

    // ------------------------------------------------------------------
    // switchover sequencing
    // ------------------------------------------------------------------
    assign sw_request = (main_clock_select_q != main_clock_status_q);
    assign old_tick   = main_clock_status_q ? fmx_tick_i : fih_tick_i;
    assign new_tick   = main_clock_status_q ? fih_tick_i : fmx_tick_i;

    // counts are taken on the main clock in use before the
    // change, giving 2 cycles or 2x the ratio in either direction
    mco_sw_seq u_seq (
        .ref_clk_i  (ref_clk_i),
        .resetn_i   (resetn_i),
        .request_i  (sw_request),
        .old_tick_i (old_tick),
        .new_tick_i (new_tick),
        .pending_o  (sw_pending),
        .done_o     (sw_done)
    );

    // pll handover waits for an edge of the clock being left
    assign pll_request = (pll_select_q != cpu_clock_status_q);
    assign pll_done    = pll_request &
                         (cpu_clock_status_q ? fpll_tick_i : old_tick);

    assign src_d = (pll_done ? pll_select_q : cpu_clock_status_q) ?
                   SRC_PLL :
                   ((sw_done ? main_clock_select_q : main_clock_status_q) ?
                    SRC_HIGH_SPD : SRC_INTERNAL);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            main_clock_select_q <= RST_MAIN_CLOCK_SELECT;
            pll_select_q        <= RST_PLL_SELECT;
        end else if (wr_sys) begin
            main_clock_select_q <= pwdata_i[MAIN_CLOCK_SELECT_BIT];
            pll_select_q        <= pwdata_i[PLL_SELECT_BIT] &
                                   pll_run_control_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            internal_osc_stop_q      <= RST_INTERNAL_OSC_STOP;
            main_osc_stop_q          <= RST_MAIN_OSC_STOP;
            osc_mode_select_q        <= RST_OSC_MODE_SELECT;
            ext_clock_input_select_q <= RST_EXT_CLOCK_SEL;
            pll_run_control_q        <= RST_PLL_RUN_CONTROL;
        end else if (wr_osc) begin
            if (!want_int_stop || int_stop_ok) begin
                internal_osc_stop_q <= want_int_stop;
            end
            if (!want_main_stop || main_stop_ok) begin
                main_osc_stop_q <= want_main_stop;
            end
            if (ext_sel_ok) begin
                osc_mode_select_q        <= pwdata_i[OSC_MODE_SELECT_BIT];
                ext_clock_input_select_q <= pwdata_i[EXT_CLOCK_SEL_BIT];
            end
            if (pwdata_i[PLL_RUN_CONTROL_BIT] || pll_stop_ok) begin
                pll_run_control_q <= pwdata_i[PLL_RUN_CONTROL_BIT];
            end
        end
    end

    // sticky refusal flag, write 1 to clear; a new refusal wins
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stop_refused_q <= 1'b0;
        end else if (refuse_evt) begin
            stop_refused_q <= 1'b1;
        end else if (wr_sts && pwdata_i[STOP_REFUSED_BIT]) begin
            stop_refused_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // status and clock source
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            main_clock_status_q <= RST_MAIN_CLOCK_SELECT;
            cpu_clock_status_q  <= RST_PLL_SELECT;
            cpu_src_q           <= SRC_INTERNAL;
            periph_src_q        <= SRC_INTERNAL;
        end else begin
            if (sw_done) begin
                main_clock_status_q <= main_clock_select_q;
            end
            if (pll_done) begin
                cpu_clock_status_q <= pll_select_q;
            end
            cpu_src_q    <= src_d;
            periph_src_q <= src_d;
        end
    end

    // ------------------------------------------------------------------
    // oscillator enables
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            internal_osc_en_q <= 1'b0;
            x1_osc_en_q       <= 1'b0;
            ext_clk_en_q      <= 1'b0;
            pll_en_q          <= 1'b0;
        end else begin
            internal_osc_en_q <= ~internal_osc_stop_q;
            x1_osc_en_q       <= osc_mode_select_q &
                                 ~ext_clock_input_select_q &
                                 ~main_osc_stop_q;
            ext_clk_en_q      <= osc_mode_select_q &
                                 ext_clock_input_select_q &
                                 ~main_osc_stop_q;
            pll_en_q          <= pll_run_control_q;
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prdata_q  <= {DATA_W{1'b0}};
            pslverr_q <= 1'b0;
        end else if (rd_cap) begin
            prdata_q  <= rd_mux;
            pslverr_q <= ~addr_ok;
        end else if (psel_i && !penable_i) begin
            prdata_q  <= {DATA_W{1'b0}};
            pslverr_q <= ~addr_ok;
        end
    end

    assign prdata_o          = prdata_q;
    assign pslverr_o         = pslverr_q;
    assign cpu_src_o         = cpu_src_q;
    assign periph_src_o      = periph_src_q;
    assign internal_osc_en_o = internal_osc_en_q;
    assign x1_osc_en_o       = x1_osc_en_q;
    assign ext_clk_en_o      = ext_clk_en_q;
    assign pll_en_o          = pll_en_q;

endmodule : mco_top

`default_nettype wire

/* File: tb/mco_top_asserts.sv */
/* Checker for mco_top: apb handshake, status readback and handover.
   Assumes oscillator ticks keep running while a switch is pending. */
`default_nettype none
module mco_top_asserts
    import mco_pkg::*;
(
    input wire logic              ref_clk_i,
    input wire logic              resetn_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic              pready_o,
    input wire logic              pslverr_o,
    input wire logic              fih_tick_i,
    input wire logic              fmx_tick_i,
    input wire logic              fpll_tick_i,
    input wire logic [1:0]        cpu_src_o,
    input wire logic [1:0]        periph_src_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    wire done   = psel_i && penable_i && pready_o;
    wire ctl    = paddr_i == SYS_CLK_CTRL_OFS;
    wire ctl_wr = done && pwrite_i && ctl;
    wire ctl_rd = done && !pwrite_i && ctl;
    sequence s_setup; psel_i && !penable_i; endsequence
    sequence s_answer; !pready_o ##1 pready_o; endsequence
    property p_goes(logic [1:0] from, logic [1:0] to, logic sel);
        ctl_wr && cpu_src_o == from && !pwdata_i[PLL_SELECT_BIT] &&
            pwdata_i[MAIN_CLOCK_SELECT_BIT] == sel
            |-> ##[3:40] cpu_src_o == to;
    endproperty
    AST_ONE_WAIT: assert property (s_setup |=> s_answer)
        else $error("pready not in second access cycle");
    AST_UNMAPPED: assert property (done && paddr_i > SW_STATUS_OFS |->
        pslverr_o)
        else $error("no slave error on unmapped address");
    AST_PERIPH: assert property (periph_src_o == cpu_src_o)
        else $error("peripheral clock source differs from cpu");
    AST_MAIN_STATUS: assert property (ctl_rd &&
        $past(cpu_src_o, 2) != SRC_PLL |-> prdata_o[MAIN_CLOCK_STATUS_BIT]
        == ($past(cpu_src_o, 2) == SRC_HIGH_SPD))
        else $error("main clock status wrong");
    AST_CPU_STATUS: assert property (ctl_rd |->
        prdata_o[CPU_CLOCK_STATUS_BIT] == ($past(cpu_src_o, 2) == SRC_PLL))
        else $error("cpu clock status wrong");
    AST_HOLD_OLD: assert property (ctl_wr && cpu_src_o != SRC_PLL &&
        !pwdata_i[PLL_SELECT_BIT] |=> $stable(cpu_src_o) [*2])
        else $error("source changed right after write");
    AST_OLD_EDGE: assert property ($changed(cpu_src_o) |->
        ($past(cpu_src_o) == SRC_INTERNAL ? $past(fih_tick_i) :
         $past(cpu_src_o) == SRC_HIGH_SPD ? $past(fmx_tick_i) :
         $past(fpll_tick_i)))
        else $error("handover off the old clock edge");
    AST_TO_HIGH: assert property (
        p_goes(SRC_INTERNAL, SRC_HIGH_SPD, 1'b1))
        else $error("switch to high speed not done in time");
    AST_TO_INT: assert property (
        p_goes(SRC_HIGH_SPD, SRC_INTERNAL, 1'b0))
        else $error("switch to internal not done in time");
endmodule : mco_top_asserts
`default_nettype wire

/* File: tb/tb.sv */
/* Directed bench for mco_top over apb, with oscillator tick sources.
   Assumes mco_pkg and mco_top_asserts are compiled before this file. */
`default_nettype none
module tb
    import mco_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic              clk, resetn, psel, penable, pwrite, fmx, fpll;
    logic              pready, pslverr, se, iosc_en, x1_en, ext_en, pll_en;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [1:0]        cpu_src, periph_src;
    bit   [1:0]        tc;
    bit                fih;
    int                err_count, compares, n, cyc;
    mco_top i_dut (.ref_clk_i(clk), .resetn_i(resetn), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .fih_tick_i(fih), .fmx_tick_i(fmx),
        .fpll_tick_i(fpll), .cpu_src_o(cpu_src), .periph_src_o(periph_src),
        .internal_osc_en_o(iosc_en), .x1_osc_en_o(x1_en),
        .ext_clk_en_o(ext_en), .pll_en_o(pll_en));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // internal osc at a third of the high-speed clock
    always @(posedge clk) begin
        tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
        fih <= tc == 2'h0;
        cyc <= cyc + 1;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task automatic sw(input logic [31:0] d, input logic [1:0] s,
                      input logic p);
        apb(1'b1, SYS_CLK_CTRL_OFS, d);
        n = cyc;
        if (p) rchk(SW_STATUS_OFS, 32'h1);
        while (cpu_src !== s && cyc - n < 60) begin
            @(posedge clk);
        end
        chk({30'h0, cpu_src}, {30'h0, s});
        // two periods of fih (a third of clk) plus the output register
        chk({31'h0, cyc - n <= 7}, 32'h1);
    endtask : sw
    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {resetn, psel, penable, pwrite} = '0;
        {fmx, fpll, paddr, pwdata, err_count, compares} = {2'h3, 44'h0, 64'h0};
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rchk(SYS_CLK_CTRL_OFS, 32'h0);
        rchk(OSC_CTRL_OFS, 32'h2);
        rchk(12'h00C, 32'h0);
        chk({31'h0, se}, 32'h1);
        apb(1'b1, OSC_CTRL_OFS, 32'h5);
        rchk(OSC_CTRL_OFS, 32'h4);
        rchk(SW_STATUS_OFS, 32'h2);
        chk({31'h0, x1_en}, 32'h1);
        apb(1'b1, SW_STATUS_OFS, 32'h2);
        rchk(SW_STATUS_OFS, 32'h0);
        sw(32'h10, SRC_HIGH_SPD, 1'b1);
        rchk(SYS_CLK_CTRL_OFS, 32'h30);
        apb(1'b1, OSC_CTRL_OFS, 32'h6);
        rchk(OSC_CTRL_OFS, 32'h4);
        rchk(SW_STATUS_OFS, 32'h2);
        apb(1'b1, SW_STATUS_OFS, 32'h2);
        apb(1'b1, OSC_CTRL_OFS, 32'h5);
        rchk(OSC_CTRL_OFS, 32'h5);
        chk({31'h0, iosc_en}, 32'h0);
        apb(1'b1, OSC_CTRL_OFS, 32'h4);
        sw(32'h0, SRC_INTERNAL, 1'b1);
        rchk(SYS_CLK_CTRL_OFS, 32'h0);
        apb(1'b1, OSC_CTRL_OFS, 32'h14);
        sw(32'h40, SRC_PLL, 1'b0);
        rchk(SYS_CLK_CTRL_OFS, 32'hC0);
        chk({31'h0, pll_en}, 32'h1);
        apb(1'b1, OSC_CTRL_OFS, 32'h4);
        rchk(OSC_CTRL_OFS, 32'h14);
        sw(32'h0, SRC_INTERNAL, 1'b0);
        apb(1'b1, OSC_CTRL_OFS, 32'h4);
        rchk(OSC_CTRL_OFS, 32'h4);
        apb(1'b1, OSC_CTRL_OFS, 32'hC);
        rchk(OSC_CTRL_OFS, 32'hC);
        chk({31'h0, ext_en}, 32'h1);
        summarize();
    end
    initial begin
        #250000;
        err_count++;
        summarize();
    end
endmodule : tb
bind mco_top mco_top_asserts i_chk (.ref_clk_i, .resetn_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .fih_tick_i, .fmx_tick_i, .fpll_tick_i, .cpu_src_o,
    .periph_src_o);
`default_nettype wire
